//--- pkg/npfc_pkg.sv
/*
 * Constants shared by the page flash command controller: register map,
 * command codes, page geometry and strobe timing.
 * Assumes a 50 MHz system clock and an x8 flash part.
 */
package npfc_pkg;
	// ****************************************
	// Register map
	// ****************************************
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_CMD = 8'h04;
	localparam logic [7:0] OFS_ADDR = 8'h08;
	localparam logic [7:0] OFS_DATA = 8'h0C;
	localparam logic [7:0] OFS_RDTRIG = 8'h10;
	localparam logic [7:0] OFS_STATUS = 8'h14;
	localparam int ST_BUSY = 0;
	localparam int ST_RB = 1;
	localparam int ST_REFUSED = 2;
	localparam int ST_BLKEND = 3;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// ****************************************
	// Command codes
	// ****************************************
	localparam logic [7:0] CMD_READ_A = 8'h00;
	localparam logic [7:0] CMD_READ_B = 8'h01;
	localparam logic [7:0] CMD_READ_C = 8'h50;
	localparam logic [7:0] CMD_LOAD = 8'h80;
	localparam logic [7:0] CMD_PROG = 8'h10;
	localparam logic [7:0] CMD_DUMMY = 8'h11;
	localparam logic [7:0] CMD_ERASE = 8'h60;
	localparam logic [7:0] CMD_ERCONF = 8'hD0;
	localparam logic [7:0] CMD_STAT = 8'h70;
	localparam logic [7:0] CMD_MSTAT = 8'h71;
	localparam logic [7:0] CMD_ID = 8'h90;
	localparam logic [7:0] CMD_RESET = 8'hFF;
	// ****************************************
	// Geometry
	// ****************************************
	localparam logic [9:0] COL_B = 10'h100;
	localparam logic [9:0] COL_C = 10'h200;
	localparam logic [9:0] COL_LAST = 10'h20F;
	localparam logic [4:0] PAGE_LAST = 5'h1F;
	localparam logic [2:0] PROG_ADDRS = 3'h4;
	localparam logic [2:0] ERASE_ADDRS = 3'h3;
	localparam logic [1:0] MAIN_LIMIT = 2'h1;
	localparam logic [1:0] SPARE_LIMIT = 2'h2;
	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_NS = 20;
	localparam int CYC_NS = 50;
	localparam int CYC_CLKS = (CYC_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [1:0] LO_CLKS = 2'(CYC_CLKS - 1);
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_WAITRB = 2'b01,
		ST_LOW = 2'b10,
		ST_HIGH = 2'b11
	} npfc_state_e;
	typedef enum logic [1:0] {
		K_CMD = 2'b00,
		K_ADDR = 2'b01,
		K_DWR = 2'b10,
		K_DRD = 2'b11
	} npfc_kind_e;
endpackage

//--- design/npfc_top.sv
/*
 * Host-side command controller for a page NAND flash: AXI4-Lite slave
 * whose writes become command, address and data cycles on the flash pins.
 * Assumes pins synchronous to aclk and software polling the busy bit.
 */
// Overview of operation
// - Each read strobe cycle lasts at least 50ns.
// - Software ends sequential row read by clearing the chip-select hold.
// - After the last page of a block chip-select is forced high.
// - One page programmed at most once main, twice spare, between erases; only repeat 10h programs of the last programmed page are refused.
// - Program needs 80h, four address cycles and data before confirm.
// - Erase needs 60h, three address cycles, then D0h.
// - After 11h the dummy busy time is awaited before next plane.
// - Dummy program 11h is refused while second-half pointer is active.
// - Multi-plane erase repeats setup and address before one D0h.
`timescale 1ns/10ps
module npfc_top (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// AXI4-Lite read
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// Flash pins
	output logic ce_n,
	output logic cle,
	output logic ale,
	output logic we_n,
	output logic read_strobe_n,
	output logic [7:0] io_out,
	output logic io_oe,
	input wire logic [7:0] io_in,
	input wire logic rb_n
);
	import npfc_pkg::*;

	logic aw_got_r, w_got_r, ce_hold_r, refused_r, blkend_r, ptr_b_r;
	logic spare_r, loaded_r, erase_ok_r, prog_spare_r;
	logic [7:0] awaddr_r, wbyte_r, rd_byte_r;
	logic [1:0] lane_r, cnt_r, lo_cnt_r;
	logic [2:0] addr_cnt_r;
	logic [7:0] last_cmd_r;
	logic [9:0] col_r;
	logic [23:0] row_r, last_row_r;
	npfc_state_e state_r;
	npfc_kind_e kind_r;
	logic wr_fire, go, refuse, bad_cmd, page_wrap;

	function automatic logic is_stat(input logic [7:0] c);
		return c == CMD_STAT || c == CMD_MSTAT || c == CMD_RESET;
	endfunction

	// ****************************************
	// AXI4-Lite slave
	// ****************************************
	assign wr_fire = aw_got_r && w_got_r && !bvalid;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_r <= 1'b0;
			w_got_r <= 1'b0;
			awready <= 1'b0;
			wready <= 1'b0;
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
			awaddr_r <= 8'h00;
			wbyte_r <= 8'h00;
			lane_r <= 2'h0;
		end else begin
			if (awvalid && awready) begin
				aw_got_r <= 1'b1;
				awaddr_r <= awaddr;
			end
			if (wvalid && wready) begin
				w_got_r <= 1'b1;
				wbyte_r <= wdata[7:0];
				lane_r <= {wstrb[0], wdata[0]};
			end
			if (wr_fire) begin
				aw_got_r <= 1'b0;
				w_got_r <= 1'b0;
				bvalid <= 1'b1;
				bresp <= (awaddr_r > OFS_STATUS || awaddr_r[1:0] != 2'h0)
					? RESP_SLVERR : RESP_OKAY;
			end else if (bvalid && bready) begin
				bvalid <= 1'b0;
			end
			awready <= !aw_got_r && !(awvalid && awready) && !bvalid;
			wready <= !w_got_r && !(wvalid && wready) && !bvalid;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b0;
			rvalid <= 1'b0;
			rdata <= 32'h0;
			rresp <= RESP_OKAY;
		end else begin
			arready <= !rvalid && !(arvalid && arready);
			if (arvalid && arready) begin
				rvalid <= 1'b1;
				rresp <= RESP_OKAY;
				case (araddr)
				OFS_CTRL: rdata <= {31'h0, ce_hold_r};
				OFS_DATA: rdata <= {24'h0, rd_byte_r};
				OFS_STATUS: rdata <= {28'h0, blkend_r, refused_r, rb_n,
					state_r != ST_IDLE};
				OFS_CMD, OFS_ADDR, OFS_RDTRIG: rdata <= 32'h0;
				default: begin
					rdata <= 32'h0;
					rresp <= RESP_SLVERR;
				end
				endcase
			end else if (rvalid && rready) begin
				rvalid <= 1'b0;
			end
		end
	end

	// ****************************************
	// Request checks
	// ****************************************
	// A cycle is only started when the engine is idle; a write other than to
	// CTRL or STATUS that lands while busy is dropped and flagged, so software must poll first.
	assign go = wr_fire && lane_r[1] && state_r == ST_IDLE &&
		(awaddr_r == OFS_CMD || awaddr_r == OFS_ADDR ||
		awaddr_r == OFS_DATA || awaddr_r == OFS_RDTRIG);
	always_comb begin
		bad_cmd = 1'b0;
		if (wbyte_r == CMD_DUMMY && ptr_b_r)
			bad_cmd = 1'b1;
		if ((wbyte_r == CMD_PROG || wbyte_r == CMD_DUMMY) && !loaded_r)
			bad_cmd = 1'b1;
		if (wbyte_r == CMD_PROG && row_r == last_row_r &&
			cnt_r >= (prog_spare_r ? SPARE_LIMIT : MAIN_LIMIT))
			bad_cmd = 1'b1;
		if (wbyte_r == CMD_ERCONF && !erase_ok_r)
			bad_cmd = 1'b1;
	end
	assign refuse = go && awaddr_r == OFS_CMD && bad_cmd;
	assign page_wrap = state_r == ST_HIGH && kind_r == K_DRD &&
		lo_cnt_r == 2'h0 && col_r == COL_LAST;

	// ****************************************
	// Sequence tracking
	// ****************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ptr_b_r <= 1'b0;
			spare_r <= 1'b0;
			loaded_r <= 1'b0;
			erase_ok_r <= 1'b0;
			addr_cnt_r <= 3'h0;
			last_cmd_r <= CMD_READ_A;
			row_r <= 24'h0;
			last_row_r <= 24'h0;
			cnt_r <= 2'h0;
			prog_spare_r <= 1'b0;
			col_r <= 10'h0;
		end else if (go && !refuse && awaddr_r == OFS_CMD) begin
			last_cmd_r <= wbyte_r;
			addr_cnt_r <= 3'h0;
			case (wbyte_r)
			CMD_READ_A: begin
				spare_r <= 1'b0;
				ptr_b_r <= 1'b0;
			end
			CMD_READ_B: begin
				spare_r <= 1'b0;
				ptr_b_r <= 1'b1;
			end
			CMD_READ_C: spare_r <= 1'b1;
			CMD_LOAD: loaded_r <= 1'b0;
			CMD_ERASE: erase_ok_r <= 1'b0;
			CMD_PROG: begin
				if (row_r == last_row_r)
					cnt_r <= cnt_r + 2'h1;
				else
					cnt_r <= 2'h1;
				last_row_r <= row_r;
				prog_spare_r <= spare_r;
				ptr_b_r <= 1'b0;
				loaded_r <= 1'b0;
			end
			CMD_DUMMY: begin
				ptr_b_r <= 1'b0;
				loaded_r <= 1'b0;
			end
			CMD_ERCONF: begin
				cnt_r <= 2'h0;
				ptr_b_r <= 1'b0;
				erase_ok_r <= 1'b0;
			end
			CMD_RESET: ptr_b_r <= 1'b0;
			default: ptr_b_r <= ptr_b_r;
			endcase
		end else if (go && awaddr_r == OFS_ADDR) begin
			addr_cnt_r <= addr_cnt_r + 3'h1;
			row_r <= {wbyte_r, row_r[23:8]};
			if (addr_cnt_r == 3'h0)
				col_r <= spare_r ? (COL_C | {6'h0, wbyte_r[3:0]}) :
					((ptr_b_r ? COL_B : 10'h0) | {2'h0, wbyte_r});
			if (last_cmd_r == CMD_ERASE && addr_cnt_r == ERASE_ADDRS - 3'h1)
				erase_ok_r <= 1'b1;
		end else if (go && awaddr_r == OFS_DATA) begin
			if (last_cmd_r == CMD_LOAD && addr_cnt_r == PROG_ADDRS)
				loaded_r <= 1'b1;
		end else if (page_wrap) begin
			col_r <= spare_r ? COL_C : 10'h0;
			ptr_b_r <= 1'b0;
			row_r[4:0] <= row_r[4:0] + 5'h1;
		end else if (state_r == ST_HIGH && kind_r == K_DRD &&
			lo_cnt_r == 2'h0) begin
			col_r <= col_r + 10'h1;
		end
	end

	// ****************************************
	// Control and status flags
	// ****************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ce_hold_r <= 1'b0;
			refused_r <= 1'b0;
			blkend_r <= 1'b0;
		end else begin
			if (wr_fire && awaddr_r == OFS_CTRL && lane_r[1])
				ce_hold_r <= lane_r[0];
			if (page_wrap && row_r[4:0] == PAGE_LAST)
				ce_hold_r <= 1'b0;
			// Sticky flags: a new event wins over a clear in the same cycle
			if (wr_fire && awaddr_r == OFS_STATUS && lane_r[1]) begin
				refused_r <= 1'b0;
				blkend_r <= 1'b0;
			end
			if (refuse || (wr_fire && lane_r[1] && state_r != ST_IDLE &&
				awaddr_r != OFS_CTRL && awaddr_r != OFS_STATUS))
				refused_r <= 1'b1;
			if (page_wrap && row_r[4:0] == PAGE_LAST)
				blkend_r <= 1'b1;
		end
	end

	// ****************************************
	// Pin cycle engine
	// ****************************************
	// Ready/busy is sampled just before each strobe except a 70h, 71h or FFh
	// command; a busy edge that the device raises late after a confirm is caught on the next request.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_r <= ST_IDLE;
			kind_r <= K_CMD;
			lo_cnt_r <= 2'h0;
			ce_n <= 1'b1;
			cle <= 1'b0;
			ale <= 1'b0;
			we_n <= 1'b1;
			read_strobe_n <= 1'b1;
			io_out <= 8'h00;
			io_oe <= 1'b0;
			rd_byte_r <= 8'h00;
		end else begin
			case (state_r)
			ST_IDLE: begin
				ce_n <= !ce_hold_r;
				io_oe <= 1'b0;
				cle <= 1'b0;
				ale <= 1'b0;
				if (go && !refuse) begin
					ce_n <= 1'b0;
					io_out <= wbyte_r;
					case (awaddr_r)
					OFS_CMD: kind_r <= K_CMD;
					OFS_ADDR: kind_r <= K_ADDR;
					OFS_DATA: kind_r <= K_DWR;
					default: kind_r <= K_DRD;
					endcase
					cle <= awaddr_r == OFS_CMD;
					ale <= awaddr_r == OFS_ADDR;
					io_oe <= awaddr_r != OFS_RDTRIG;
					state_r <= ST_WAITRB;
				end
			end
			ST_WAITRB: begin
				if (rb_n || (kind_r == K_CMD && is_stat(io_out))) begin
					state_r <= ST_LOW;
					lo_cnt_r <= LO_CLKS;
					we_n <= kind_r == K_DRD;
					read_strobe_n <= kind_r != K_DRD;
				end
			end
			ST_LOW: begin
				lo_cnt_r <= lo_cnt_r - 2'h1;
				if (lo_cnt_r == 2'h1) begin
					state_r <= ST_HIGH;
					lo_cnt_r <= 2'h0;
					we_n <= 1'b1;
					read_strobe_n <= 1'b1;
					if (kind_r == K_DRD)
						rd_byte_r <= io_in;
				end
			end
			ST_HIGH: begin
				state_r <= ST_IDLE;
				ce_n <= !ce_hold_r;
			end
			default: state_r <= ST_IDLE;
			endcase
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	sequence seq_we_pulse;
		!we_n [*2] ##1 we_n;
	endsequence
	sequence seq_re_pulse;
		!read_strobe_n [*2] ##1 read_strobe_n;
	endsequence
	AST_WE_WIDTH: assert property (@(posedge aclk) disable iff (!aresetn)
		$fell(we_n) |-> seq_we_pulse)
		else $error("write strobe cycle too short");
	AST_RE_WIDTH: assert property (@(posedge aclk) disable iff (!aresetn)
		$fell(read_strobe_n) |-> seq_re_pulse)
		else $error("read strobe cycle too short");
	AST_BUSY_CMD: assert property (@(posedge aclk) disable iff (!aresetn)
		$fell(we_n) && cle && !is_stat(io_out) |-> $past(rb_n))
		else $error("command sent while flash busy");
	AST_BUSY_READ: assert property (@(posedge aclk) disable iff (!aresetn)
		$fell(read_strobe_n) |-> $past(rb_n))
		else $error("data read while flash busy");
	AST_IO_DIR: assert property (@(posedge aclk) disable iff (!aresetn)
		!read_strobe_n |-> !io_oe)
		else $error("data bus driven during read strobe");
	AST_DUMMY_PTRB: assert property (@(posedge aclk) disable iff (!aresetn)
		go && awaddr_r == OFS_CMD && wbyte_r == CMD_DUMMY && ptr_b_r
		|=> refused_r && state_r == ST_IDLE)
		else $error("dummy program with second-half pointer");
	AST_PROG_DATA: assert property (@(posedge aclk) disable iff (!aresetn)
		state_r == ST_IDLE && go && awaddr_r == OFS_CMD &&
		wbyte_r == CMD_PROG && !loaded_r |=> state_r == ST_IDLE)
		else $error("confirm sent without loaded data");
	AST_ERASE_ADDR: assert property (@(posedge aclk) disable iff (!aresetn)
		go && awaddr_r == OFS_CMD && wbyte_r == CMD_ERCONF && !erase_ok_r
		|=> refused_r && state_r == ST_IDLE)
		else $error("erase confirm without three address cycles");
	AST_BLOCK_END: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(blkend_r) |-> !ce_hold_r ##[1:3] ce_n)
		else $error("chip select not released at block end");
	AST_PROG_LIMIT: assert property (@(posedge aclk) disable iff (!aresetn)
		go && awaddr_r == OFS_CMD && wbyte_r == CMD_PROG &&
		row_r == last_row_r && !prog_spare_r && cnt_r == MAIN_LIMIT
		|=> refused_r)
		else $error("main page programmed twice");
endmodule

//--- verification/npfc_flash_model.sv
/*
 * Behavioural page flash device facing the controller's flash pins.
 * Assumes pins move only on controller clock edges; times scaled down.
 */
`timescale 1ns/10ps
module npfc_flash_model #(
	parameter int XFER_NS = 2000,
	parameter int DBSY_NS = 200,
	parameter int WORK_NS = 3000,
	// Identity bytes: values are arbitrary
	parameter logic [7:0] MAKER_ID = 8'h3A,
	parameter logic [7:0] DEV_ID = 8'h5C
) (
	// Flash pins
	input wire logic ce_n,
	input wire logic cle,
	input wire logic ale,
	input wire logic we_n,
	input wire logic read_strobe_n,
	input wire logic [7:0] io_out,
	output logic [7:0] io_in,
	output logic rb_n
);
	// ****************************************
	// Command and data behaviour
	// ****************************************
	logic [7:0] out_b = 8'h00, op = 8'h00, row = 8'h00;
	logic [9:0] col = 10'h000, base = 10'h000;
	logic [2:0] nadr = 3'h0;
	logic [1:0] idx = 2'h0;
	logic [1:0] mode = 2'h0; // Powers up in page read
	logic spare = 1'b0, loaded = 1'b0;
	// Released bus shows the inverse of the last byte, never a held value
	assign io_in = (!ce_n && !read_strobe_n) ? out_b : ~out_b;
	initial rb_n = 1'b1;
	task automatic busy(input int t);
		rb_n = 1'b0;
		rb_n <= #(t) 1'b1;
	endtask
	always @(posedge we_n) if (!ce_n) begin
		if (cle && (rb_n || io_out inside {8'h70, 8'h71, 8'hFF})) begin
			op = io_out;
			nadr = 3'h0;
			case (io_out)
			8'h00, 8'h01: begin
				mode = 2'h0;
				spare = 1'b0;
				base = io_out[0] ? 10'h100 : 10'h000;
			end
			8'h50: begin
				mode = 2'h0;
				spare = 1'b1;
				base = 10'h200;
			end
			8'h80: loaded = 1'b0;
			8'h10, 8'h11: begin
				if (loaded) busy(io_out[0] ? DBSY_NS : WORK_NS);
				mode = 2'h1;
			end
			8'hD0: begin
				busy(WORK_NS);
				mode = 2'h1;
			end
			8'h70, 8'h71: mode = 2'h1;
			8'h90: begin
				mode = 2'h2;
				idx = 2'h0;
			end
			default: mode = 2'h0;
			endcase
		end else if (ale) begin
			nadr = nadr + 3'h1;
			if (nadr == 3'h1) col = base + (spare ? {6'h0, io_out[3:0]} :
				{2'h0, io_out});
			if (nadr == 3'h2) row = io_out;
			if (nadr == 3'h4 && op inside {8'h00, 8'h01, 8'h50}) begin
				busy(XFER_NS);
				if (base == 10'h100) base = 10'h000;
			end
		end else if (!cle) loaded = 1'b1;
	end
	always @(negedge read_strobe_n) if (!ce_n) begin
		case (mode)
		2'h1: out_b = {1'b1, rb_n, 6'h00};
		2'h2: begin
			case (idx)
			2'h0: out_b = MAKER_ID;
			2'h1: out_b = DEV_ID;
			2'h2: out_b = 8'h17;
			default: out_b = 8'h4B;
			endcase
			idx = idx + 2'h1;
		end
		default: begin
			out_b = col[7:0] ^ row;
			col = col + 10'h1;
			if (col == 10'd528) begin
				col = spare ? 10'h200 : 10'h000;
				row = row + 8'h1;
				busy(XFER_NS);
			end
		end
		endcase
	end
endmodule

//--- verification/tb_nand_page_flash_command_engine.sv
/*
 * Self-checking bench: AXI4-Lite master, expectation queue and monitor.
 * Assumes the controller top and the flash model beside it.
 */
`timescale 1ns/10ps
module tb_nand_page_flash_command_engine;
	import npfc_pkg::*;
	// ****************************************
	// Signals
	// ****************************************
	logic aclk = 1'b0, aresetn = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00, io_out, io_in, c, r;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0, rdata, d;
	logic [3:0] wstrb = 4'hF;
	logic [1:0] bresp, rresp;
	logic awready, wready, bvalid, arready, rvalid;
	logic ce_n, cle, ale, we_n, read_strobe_n, io_oe, rb_n;
	logic [34:0] notes[$];
	logic [34:0] nt;
	logic [1:0] bnotes[$];
	logic [1:0] nb;
	int mismatches = 0, compares = 0, cycles = 0, seed = 44;
	always #10 aclk = ~aclk;
	npfc_top dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
		.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n),
		.read_strobe_n(read_strobe_n), .io_out(io_out), .io_oe(io_oe),
		.io_in(io_in), .rb_n(rb_n));
	npfc_flash_model flash (.ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n),
		.read_strobe_n(read_strobe_n), .io_out(io_out), .io_in(io_in),
		.rb_n(rb_n));
	// ****************************************
	// Tasks
	// ****************************************
	task automatic chk(input string n, input logic [33:0] seen, exp);
		compares++;
		if (seen !== exp) begin
			mismatches++;
			$display("Error %s expected %h seen %h", n, exp, seen);
		end
	endtask
	task automatic end_of_test();
		$display("Checks %0d, mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic wrx(input logic [7:0] a, v, input logic [1:0] e);
		bnotes.push_back(e);
		@(posedge aclk);
		awaddr <= a;
		wdata <= {24'h0, v};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		bready <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, v);
		wrx(a, v, RESP_OKAY);
	endtask
	task automatic rd(input logic [7:0] a, input logic ck,
		input logic [33:0] exp);
		notes.push_back({ck, exp});
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		rready <= 1'b0;
		d = rdata;
	endtask
	// Polls until the engine is idle and the flash is ready
	task automatic eng(input logic [7:0] a, v);
		wr(a, v);
		do rd(OFS_STATUS, 1'b0, 34'h0); while (d[1:0] !== 2'b10);
	endtask
	task automatic get(input logic [7:0] e);
		eng(OFS_RDTRIG, 8'h00);
		rd(OFS_DATA, 1'b1, {RESP_OKAY, 24'h0, e});
	endtask
	task automatic addr(input logic [7:0] a0, a1, input int n);
		eng(OFS_ADDR, a0);
		eng(OFS_ADDR, a1);
		repeat (n - 2) eng(OFS_ADDR, 8'h00);
	endtask
	// Reads n bytes from column c0; lo is the wrap column
	task automatic run(input int c0, lo, n);
		int cc;
		logic [7:0] rr;
		cc = c0;
		rr = r;
		repeat (n) begin
			get(8'(cc) ^ rr);
			cc++;
			if (cc == 528) begin
				cc = lo;
				rr++;
			end
		end
	endtask
	// ****************************************
	// Monitor, timeout and main sequence
	// ****************************************
	always @(posedge aclk) if (rvalid && rready) begin
		nt = notes.pop_front();
		if (nt[34]) chk("rdata", {rresp, rdata}, nt[33:0]);
	end
	always @(posedge aclk) if (bvalid && bready) begin
		nb = bnotes.pop_front();
		chk("bresp", {32'h0, bresp}, {32'h0, nb});
	end
	always @(posedge aclk) begin
		cycles++;
		if (cycles == 60000) begin
			mismatches++;
			end_of_test();
		end
	end
	initial begin
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		rd(OFS_STATUS, 1'b1, {RESP_OKAY, 32'h2});
		rd(8'h18, 1'b1, {RESP_SLVERR, 32'h0});
		wrx(8'h18, 8'h00, RESP_SLVERR);
		eng(OFS_CMD, CMD_ID);
		eng(OFS_ADDR, 8'h00);
		get(8'h3A);
		get(8'h5C);
		get(8'h17);
		get(8'h4B);
		eng(OFS_CMD, CMD_PROG);
		rd(OFS_STATUS, 1'b1, {RESP_OKAY, 32'h6});
		wr(OFS_STATUS, 8'h00);
		rd(OFS_STATUS, 1'b1, {RESP_OKAY, 32'h2});
		// Page index kept below the block end
		c = 8'($random(seed));
		r = 8'($random(seed)) & 8'hEF;
		eng(OFS_CMD, CMD_READ_A);
		addr(c, r, 4);
		run(c, 0, 3);
		eng(OFS_CMD, CMD_READ_B);
		addr(8'hFE, r, 4);
		run(510, 0, 20);
		eng(OFS_CMD, CMD_READ_C);
		addr(8'hF3, r, 4);
		run(515, 512, 15);
		// Without the low strobe lane the hold bit must not move
		wstrb <= 4'h0;
		wr(OFS_CTRL, 8'h01);
		wstrb <= 4'hF;
		rd(OFS_CTRL, 1'b1, {RESP_OKAY, 32'h0});
		wr(OFS_CTRL, 8'h01);
		rd(OFS_CTRL, 1'b1, {RESP_OKAY, 32'h1});
		chk("ce_n", {33'h0, ce_n}, 34'h0);
		// Last spare byte of the last page in a block
		r = 8'h1F;
		eng(OFS_CMD, CMD_READ_C);
		addr(8'h0F, r, 4);
		run(527, 512, 1);
		rd(OFS_STATUS, 1'b1, {RESP_OKAY, 32'hA});
		rd(OFS_CTRL, 1'b1, {RESP_OKAY, 32'h0});
		chk("ce_n", {33'h0, ce_n}, 34'h1);
		wr(OFS_STATUS, 8'h00);
		eng(OFS_CMD, CMD_READ_B);
		eng(OFS_CMD, CMD_DUMMY);
		rd(OFS_STATUS, 1'b1, {RESP_OKAY, 32'h6});
		wr(OFS_STATUS, 8'h00);
		for (int p = 0; p < 2; p++) begin
			eng(OFS_CMD, CMD_READ_A); // Clears any second-half pointer
			eng(OFS_CMD, CMD_LOAD);
			addr(8'h00, 8'(p * 64 + 3), 4); // Fresh pages only
			eng(OFS_DATA, 8'($random(seed)));
			eng(OFS_CMD, p ? CMD_PROG : CMD_DUMMY);
		end
		rd(OFS_STATUS, 1'b1, {RESP_OKAY, 32'h2});
		eng(OFS_CMD, CMD_MSTAT);
		get({2'b11, 6'h00});
		get({2'b11, 6'h00});
		// Second main-area program of the same page
		eng(OFS_CMD, CMD_LOAD);
		addr(8'h00, 8'h43, 4);
		eng(OFS_DATA, 8'h5A);
		eng(OFS_CMD, CMD_PROG);
		rd(OFS_STATUS, 1'b1, {RESP_OKAY, 32'h6});
		wr(OFS_STATUS, 8'h00);
		for (int p = 0; p < 2; p++) begin
			eng(OFS_CMD, CMD_ERASE);
			addr(8'(p * 64), 8'h01, 3);
		end
		eng(OFS_CMD, CMD_ERCONF);
		rd(OFS_STATUS, 1'b1, {RESP_OKAY, 32'h2});
		eng(OFS_CMD, CMD_STAT);
		get({2'b11, 6'h00});
		eng(OFS_CMD, CMD_ERCONF);
		rd(OFS_STATUS, 1'b1, {RESP_OKAY, 32'h6});
		end_of_test();
	end
endmodule
